// ### rtl/hdlc_addr_defines.svh
`ifndef HDLC_ADDR_DEFINES_SVH
`define HDLC_ADDR_DEFINES_SVH

// ****************************************
// Register indices, byte address is four times the index.
// ****************************************
// Shared indices carry the name of their read side.
`define IDX_TX_FIRST   8'h24
`define IDX_RX_COUNT   8'h25
`define IDX_RX_ADDR    8'h26
`define IDX_RX_STATUS  8'h27
`define IDX_TEI_FIRST  8'h28
`define IDX_TEI_SECOND 8'h29
`define IDX_MODE      8'h2c
`define IDX_CMD       8'h2d
`define IDX_STAT      8'h2e

// ****************************************
// Field positions and constants.
// ****************************************
`define ST_DATA       7
`define ST_OVF        6
`define ST_CRC        5
`define ST_ABORT      4
`define ST_SAPI_HI    3
`define ST_SAPI_LO    2
`define ST_CR         1
`define ST_TEI        0
`define CR_BIT        1
`define SIDE_BIT      1
`define MODULO_BIT    1
`define MODE_TWO_BYTE 3
`define CMD_DONE      0
`define GROUP_SAPI    6'h3f
`define GROUP_TEI     7'h7f
`define COUNT_RESET   8'h00
`define REG_RESET     8'h00
`define SA_FIRST      2'h2
`define SA_SECOND     2'h0
`define SA_GROUP      2'h1

`endif

// ### rtl/hdlc_addr_pkg.sv
package hdlc_addr_pkg;
  typedef enum logic [2:0] {
    MODE_AUTO,
    MODE_NONAUTO,
    MODE_TRANSP1,
    MODE_TRANSP2,
    MODE_TRANSP3
  } mode_t;
  typedef enum logic [2:0] {
    RX_ADDR1,
    RX_ADDR2,
    RX_CTRL,
    RX_DATA,
    RX_SKIP
  } rx_state_t;
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_FIRST,
    TX_SECOND
  } tx_state_t;
endpackage

// ### rtl/hdlc_address_recognition_status.sv
// Summary of operation
// - Two-byte: first tx byte bit 1 replaced.
// - Sent C/R follows side select and frame type.
// - One-byte: command uses first, response second.
// - Second byte is TEI; auto-mode only.
// - Low count: block size plus 32-byte blocks.
// - Thirty-two received bytes read as 0x20.
// - Transparent mode 1 keeps first address byte.
// - Received C/R interpreted by side select.
// - Two-byte: first byte compared to both SAPIs, group.
// - Data-available flag shows FIFO holds data.
// - Overflow flag when a byte was lost.
// - CRC flag set when check sequence correct and no abort.
// - Abort flag set on seven ones.
// - Group SAPI FC/FE and group TEI FF.
// - Match codes per address length table.
// - Equal SAPIs: second pair reports 10 and 1.
// - Status frozen until receive-complete command.
// - Match bits valid only in listed modes.
// - Modulo select sets control field length in auto-mode.
// - Status C/R reports bit as received.
`timescale 1ns/1ns
`include "hdlc_addr_defines.svh"

module hdlc_address_recognition_status (
  // Clock and reset.
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  // APB slave.
  input  wire logic       psel_in,
  input  wire logic       penable_in,
  input  wire logic       pwrite_in,
  input  wire logic [9:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic            pready_out,
  output logic            pslverr_out,
  // Received byte stream from the deframer.
  input  wire logic       rx_valid_in,
  input  wire logic [7:0] rx_byte_in,
  input  wire logic       rx_end_in,
  input  wire logic       rx_crc_ok_in,
  input  wire logic       rx_abort_in,
  input  wire logic       rx_fifo_ready_in,
  output logic            rx_fifo_push_out,
  output logic      [7:0] rx_fifo_data_out,
  output logic            message_end_event_out,
  output logic            rx_is_command_out,
  // Transmit address supply.
  input  wire logic       tx_req_in,
  input  wire logic       tx_response_in,
  input  wire logic       tx_ready_in,
  output logic            tx_valid_out,
  output logic      [7:0] tx_byte_out,
  output logic            modulo_select_out
);

  // ****************************************
  // Helpers.
  // ****************************************
  function automatic logic sapi_eq(input logic [7:0] a, input logic [7:0] b);
    return a[7:2] == b[7:2];
  endfunction

  function automatic logic tei_eq(input logic [7:0] a, input logic [7:0] b);
    return a[7:1] == b[7:1];
  endfunction

  function automatic hdlc_addr_pkg::mode_t decode_mode(input logic [2:0] f);
    case (f)
      3'h1: return hdlc_addr_pkg::MODE_NONAUTO;
      3'h2: return hdlc_addr_pkg::MODE_TRANSP1;
      3'h3: return hdlc_addr_pkg::MODE_TRANSP2;
      3'h4: return hdlc_addr_pkg::MODE_TRANSP3;
      default: return hdlc_addr_pkg::MODE_AUTO;
    endcase
  endfunction

  // ****************************************
  // Register file and APB.
  // ****************************************
  logic [7:0] tx_address_first, next_tx_address_first;
  logic [7:0] tx_address_second, next_tx_address_second;
  logic [7:0] service_point_first, next_service_point_first;
  logic [7:0] service_point_second, next_service_point_second;
  logic [7:0] endpoint_id_first, next_endpoint_id_first;
  logic [7:0] endpoint_id_second, next_endpoint_id_second;
  logic [3:0] mode_reg, next_mode_reg;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        done_write;
  logic [7:0]  rx_byte_count_low;
  logic [7:0]  rx_first_address_byte;
  logic [7:0]  rx_frame_status;
  logic        held;

  wire logic [7:0] idx = paddr_in[9:2];
  wire logic wr_go = psel_in & penable_in & pready_out & pwrite_in;
  wire hdlc_addr_pkg::mode_t mode = decode_mode(mode_reg[2:0]);
  wire logic two_byte = mode_reg[`MODE_TWO_BYTE];
  wire logic side_select = service_point_first[`SIDE_BIT];

  always_comb begin
    next_tx_address_first     = tx_address_first;
    next_tx_address_second    = tx_address_second;
    next_service_point_first  = service_point_first;
    next_service_point_second = service_point_second;
    next_endpoint_id_first    = endpoint_id_first;
    next_endpoint_id_second   = endpoint_id_second;
    next_mode_reg             = mode_reg;
    next_pready               = psel_in & ~penable_in;
    next_prdata               = 32'h0000_0000;
    next_pslverr              = 1'b0;
    done_write                = 1'b0;
    if (psel_in & ~penable_in) begin
      // Reads at shared indices take storage that writes never touch, so those indices stay independent.
      case (idx)
        `IDX_TX_FIRST, `IDX_TEI_FIRST, `IDX_TEI_SECOND, `IDX_CMD: next_prdata = 32'h0000_0000;
        `IDX_RX_COUNT:  next_prdata = {24'h00_0000, rx_byte_count_low};
        `IDX_RX_ADDR:   next_prdata = {24'h00_0000, rx_first_address_byte};
        `IDX_RX_STATUS: next_prdata = {24'h00_0000, rx_frame_status};
        `IDX_MODE: next_prdata = {28'h000_0000, mode_reg};
        `IDX_STAT: next_prdata = {29'h0000_0000, modulo_select_out, rx_is_command_out, held};
        default:   next_pslverr = 1'b1;
      endcase
    end
    if (wr_go && !pslverr_out) begin
      case (idx)
        `IDX_TX_FIRST:   next_tx_address_first     = pwdata_in[7:0];
        `IDX_RX_COUNT:   next_tx_address_second    = pwdata_in[7:0];
        `IDX_RX_ADDR:    next_service_point_first  = pwdata_in[7:0];
        `IDX_RX_STATUS:  next_service_point_second = pwdata_in[7:0];
        `IDX_TEI_FIRST:  next_endpoint_id_first    = pwdata_in[7:0];
        `IDX_TEI_SECOND: next_endpoint_id_second   = pwdata_in[7:0];
        `IDX_MODE:       next_mode_reg             = pwdata_in[3:0];
        `IDX_CMD:        done_write                = pwdata_in[`CMD_DONE];
        default:         next_mode_reg             = mode_reg;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tx_address_first     <= `REG_RESET;
      tx_address_second    <= `REG_RESET;
      service_point_first  <= `REG_RESET;
      service_point_second <= `REG_RESET;
      endpoint_id_first    <= `REG_RESET;
      endpoint_id_second   <= `REG_RESET;
      mode_reg             <= 4'h0;
      prdata_out           <= 32'h0000_0000;
      pready_out           <= 1'b0;
      pslverr_out          <= 1'b0;
    end else begin
      tx_address_first     <= next_tx_address_first;
      tx_address_second    <= next_tx_address_second;
      service_point_first  <= next_service_point_first;
      service_point_second <= next_service_point_second;
      endpoint_id_first    <= next_endpoint_id_first;
      endpoint_id_second   <= next_endpoint_id_second;
      mode_reg             <= next_mode_reg;
      prdata_out           <= next_prdata;
      pready_out           <= next_pready;
      pslverr_out          <= next_pslverr;
    end
  end

  // ****************************************
  // Receive address recognition and status.
  // ****************************************
  hdlc_addr_pkg::rx_state_t rx_state, next_rx_state;
  logic [7:0] next_rx_byte_count_low, next_rx_first_address_byte, next_rx_frame_status;
  logic       next_held, next_message_end, next_push, next_is_command, next_modulo;
  logic [7:0] next_push_data;
  logic [7:0] w_cnt, next_w_cnt;
  logic       w_ovf, next_w_ovf;
  logic [1:0] w_sa, next_w_sa;
  logic       w_ta, next_w_ta, w_cr, next_w_cr;
  logic [2:0] w_sm, next_w_sm;
  logic       ctl_left, next_ctl_left;
  logic       s1, s2, sg, t1, t2, tg;

  // Only auto-mode with modulo 128 carries a two-byte control field.
  wire logic two_ctl = (mode == hdlc_addr_pkg::MODE_AUTO) && service_point_second[`MODULO_BIT];

  always_comb begin
    next_rx_state              = rx_state;
    next_rx_byte_count_low     = rx_byte_count_low;
    next_rx_first_address_byte = rx_first_address_byte;
    next_rx_frame_status       = rx_frame_status;
    next_held                  = held & ~done_write;
    next_message_end           = 1'b0;
    next_push                  = 1'b0;
    next_push_data             = rx_fifo_data_out;
    next_is_command            = rx_is_command_out;
    next_modulo                = service_point_second[`MODULO_BIT];
    next_w_cnt                 = w_cnt;
    next_w_ovf                 = w_ovf;
    next_w_sa                  = w_sa;
    next_w_ta                  = w_ta;
    next_w_cr                  = w_cr;
    next_w_sm                  = w_sm;
    next_ctl_left              = ctl_left;
    s1 = sapi_eq(rx_byte_in, service_point_first);
    s2 = sapi_eq(rx_byte_in, service_point_second);
    sg = rx_byte_in[7:2] == `GROUP_SAPI;
    t1 = tei_eq(rx_byte_in, endpoint_id_first);
    t2 = tei_eq(rx_byte_in, endpoint_id_second);
    tg = rx_byte_in[7:1] == `GROUP_TEI;
    if (rx_end_in | rx_abort_in) begin
      // A frame end meeting the acknowledge in the same cycle is still reported.
      if (rx_state != hdlc_addr_pkg::RX_SKIP && (!held || done_write)) begin
        next_held                  = 1'b1;
        next_message_end           = 1'b1;
        next_rx_byte_count_low     = w_cnt;
        next_rx_frame_status       = {w_cnt != 8'h00, w_ovf, rx_crc_ok_in & ~rx_abort_in, rx_abort_in,
                                      w_sa, w_cr, w_ta};
        // Subscriber side takes C/R one as command, network side zero.
        next_is_command            = w_cr ^ side_select;
      end
      next_rx_state = (mode == hdlc_addr_pkg::MODE_TRANSP2) ? hdlc_addr_pkg::RX_DATA : hdlc_addr_pkg::RX_ADDR1;
      next_w_cnt    = 8'h00;
      next_w_ovf    = 1'b0;
      next_w_sa     = 2'h0;
      next_w_ta     = 1'b0;
      next_w_cr     = 1'b0;
      next_ctl_left = 1'b0;
    end else if (rx_valid_in) begin
      case (rx_state)
        hdlc_addr_pkg::RX_ADDR1: begin
          next_w_cr = rx_byte_in[`CR_BIT];
          next_w_sm = {s1, s2, sg};
          if (mode == hdlc_addr_pkg::MODE_TRANSP1) begin
            next_rx_first_address_byte = rx_byte_in;
            next_rx_state              = hdlc_addr_pkg::RX_ADDR2;
          end else if (mode == hdlc_addr_pkg::MODE_TRANSP3) begin
            // Only the SAPI code is meaningful here; the TEI bit stays zero.
            next_w_sa     = s1 ? `SA_FIRST : (s2 ? `SA_SECOND : `SA_GROUP);
            next_rx_state = (s1 | s2 | sg) ? hdlc_addr_pkg::RX_DATA : hdlc_addr_pkg::RX_SKIP;
          end else if (two_byte) begin
            next_rx_state = (s1 | s2 | sg) ? hdlc_addr_pkg::RX_ADDR2 : hdlc_addr_pkg::RX_SKIP;
          end else begin
            next_w_ta     = t1;
            next_rx_state = (t1 | t2) ? hdlc_addr_pkg::RX_CTRL : hdlc_addr_pkg::RX_SKIP;
          end
        end
        hdlc_addr_pkg::RX_ADDR2: begin
          next_rx_state = hdlc_addr_pkg::RX_CTRL;
          if (mode == hdlc_addr_pkg::MODE_TRANSP1) begin
            next_w_ta = t1 | t2;
            if (!(t1 | t2 | tg)) begin
              next_rx_state = hdlc_addr_pkg::RX_SKIP;
            end
          end else if (w_sm[2] && (tg || t1 || (w_sm[1] && t2))) begin
            // First SAPI wins, so equal SAPIs report the first code.
            next_w_sa = `SA_FIRST;
            next_w_ta = ~tg;
          end else if (w_sm[1] && (tg || t2)) begin
            next_w_sa = `SA_SECOND;
            next_w_ta = ~tg;
          end else if (w_sm[0] && (tg || t1 || t2)) begin
            next_w_sa = `SA_GROUP;
            next_w_ta = ~tg;
          end else begin
            next_rx_state = hdlc_addr_pkg::RX_SKIP;
          end
        end
        hdlc_addr_pkg::RX_CTRL: begin
          // The flag marks a first control byte taken, so it never goes stale after reset or a mode change.
          next_ctl_left = two_ctl & ~ctl_left;
          if (ctl_left || !two_ctl) begin
            next_rx_state = hdlc_addr_pkg::RX_DATA;
          end
        end
        hdlc_addr_pkg::RX_DATA: begin
          next_push_data = rx_byte_in;
          if (rx_fifo_ready_in) begin
            next_push  = 1'b1;
            next_w_cnt = w_cnt + 8'h01;
          end else begin
            next_w_ovf = 1'b1;
          end
        end
        default: next_rx_state = rx_state;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rx_state              <= hdlc_addr_pkg::RX_ADDR1;
      rx_byte_count_low     <= `COUNT_RESET;
      rx_first_address_byte <= `REG_RESET;
      rx_frame_status       <= `REG_RESET;
      held                  <= 1'b0;
      message_end_event_out <= 1'b0;
      rx_fifo_push_out      <= 1'b0;
      rx_fifo_data_out      <= 8'h00;
      rx_is_command_out     <= 1'b0;
      modulo_select_out     <= 1'b0;
      w_cnt                 <= 8'h00;
      w_ovf                 <= 1'b0;
      w_sa                  <= 2'h0;
      w_ta                  <= 1'b0;
      w_cr                  <= 1'b0;
      w_sm                  <= 3'h0;
      ctl_left              <= 1'b0;
    end else begin
      rx_state              <= next_rx_state;
      rx_byte_count_low     <= next_rx_byte_count_low;
      rx_first_address_byte <= next_rx_first_address_byte;
      rx_frame_status       <= next_rx_frame_status;
      held                  <= next_held;
      message_end_event_out <= next_message_end;
      rx_fifo_push_out      <= next_push;
      rx_fifo_data_out      <= next_push_data;
      rx_is_command_out     <= next_is_command;
      modulo_select_out     <= next_modulo;
      w_cnt                 <= next_w_cnt;
      w_ovf                 <= next_w_ovf;
      w_sa                  <= next_w_sa;
      w_ta                  <= next_w_ta;
      w_cr                  <= next_w_cr;
      w_sm                  <= next_w_sm;
      ctl_left              <= next_ctl_left;
    end
  end

  // ****************************************
  // Transmit address supply.
  // ****************************************
  hdlc_addr_pkg::tx_state_t tx_state, next_tx_state;
  logic       next_tx_valid;
  logic [7:0] next_tx_byte;

  always_comb begin
    next_tx_state = tx_state;
    next_tx_valid = tx_valid_out;
    next_tx_byte  = tx_byte_out;
    case (tx_state)
      hdlc_addr_pkg::TX_IDLE: begin
        // Address bytes are only supplied in auto-mode.
        if (tx_req_in && mode == hdlc_addr_pkg::MODE_AUTO) begin
          next_tx_state = hdlc_addr_pkg::TX_FIRST;
          next_tx_valid = 1'b1;
          if (two_byte) begin
            next_tx_byte = {tx_address_first[7:2], tx_response_in ^ side_select,
                            tx_address_first[0]};
          end else begin
            next_tx_byte = tx_response_in ? tx_address_second : tx_address_first;
          end
        end
      end
      hdlc_addr_pkg::TX_FIRST: begin
        if (tx_ready_in) begin
          if (two_byte) begin
            next_tx_state = hdlc_addr_pkg::TX_SECOND;
            next_tx_byte  = tx_address_second;
          end else begin
            next_tx_state = hdlc_addr_pkg::TX_IDLE;
            next_tx_valid = 1'b0;
          end
        end
      end
      hdlc_addr_pkg::TX_SECOND: begin
        if (tx_ready_in) begin
          next_tx_state = hdlc_addr_pkg::TX_IDLE;
          next_tx_valid = 1'b0;
        end
      end
      default: next_tx_state = hdlc_addr_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tx_state     <= hdlc_addr_pkg::TX_IDLE;
      tx_valid_out <= 1'b0;
      tx_byte_out  <= 8'h00;
    end else begin
      tx_state     <= next_tx_state;
      tx_valid_out <= next_tx_valid;
      tx_byte_out  <= next_tx_byte;
    end
  end

  // ****************************************
  // Assertions.
  // ****************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  property p_tx_cr;
    tx_state == hdlc_addr_pkg::TX_IDLE && tx_req_in && mode == hdlc_addr_pkg::MODE_AUTO && two_byte
      |=> tx_valid_out && tx_byte_out[1] == ($past(tx_response_in) ^ side_select)
          && tx_byte_out[7:2] == tx_address_first[7:2];
  endproperty
  a_tx_cr: assert property (p_tx_cr) else $error("sent C/R bit wrong");

  property p_tx_one;
    tx_state == hdlc_addr_pkg::TX_IDLE && tx_req_in && mode == hdlc_addr_pkg::MODE_AUTO && !two_byte
      |=> tx_byte_out == ($past(tx_response_in) ? tx_address_second : tx_address_first);
  endproperty
  a_tx_one: assert property (p_tx_one) else $error("one-byte address wrong");

  property p_tx_second;
    tx_state == hdlc_addr_pkg::TX_FIRST && tx_ready_in && two_byte
      |=> tx_valid_out && tx_byte_out == tx_address_second;
  endproperty
  a_tx_second: assert property (p_tx_second) else $error("second address byte wrong");

  property p_tx_auto_only;
    tx_state == hdlc_addr_pkg::TX_IDLE && mode != hdlc_addr_pkg::MODE_AUTO |=> !tx_valid_out;
  endproperty
  a_tx_auto_only: assert property (p_tx_auto_only) else $error("address sent outside auto-mode");

  property p_count;
    rx_valid_in && !rx_end_in && !rx_abort_in && rx_state == hdlc_addr_pkg::RX_DATA && rx_fifo_ready_in
      |=> rx_fifo_push_out && w_cnt == $past(w_cnt) + 8'h01;
  endproperty
  a_count: assert property (p_count) else $error("byte count not advanced");

  property p_ovf;
    rx_valid_in && !rx_end_in && !rx_abort_in && rx_state == hdlc_addr_pkg::RX_DATA && !rx_fifo_ready_in
      |=> w_ovf && !rx_fifo_push_out;
  endproperty
  a_ovf: assert property (p_ovf) else $error("lost byte not flagged");

  property p_end;
    (rx_end_in || rx_abort_in) && rx_state != hdlc_addr_pkg::RX_SKIP && !held
      |=> message_end_event_out && held && rx_byte_count_low == $past(w_cnt)
          && rx_frame_status[`ST_ABORT] == $past(rx_abort_in)
          && rx_frame_status[`ST_CRC] == ($past(rx_crc_ok_in) && !$past(rx_abort_in));
  endproperty
  a_end: assert property (p_end) else $error("frame end status wrong");

  property p_stable;
    held && !done_write |=> $stable(rx_frame_status) && $stable(rx_byte_count_low);
  endproperty
  a_stable: assert property (p_stable) else $error("status changed before acknowledge");

  property p_rx_first_address_byte;
    rx_valid_in && !rx_end_in && !rx_abort_in && rx_state == hdlc_addr_pkg::RX_ADDR1
      && mode == hdlc_addr_pkg::MODE_TRANSP1 |=> rx_first_address_byte == $past(rx_byte_in);
  endproperty
  a_rx_first_address_byte: assert property (p_rx_first_address_byte) else $error("first address byte not kept");

  c_two_byte_tx: cover property (tx_state == hdlc_addr_pkg::TX_SECOND && tx_ready_in);
  c_frame_end: cover property (message_end_event_out && rx_frame_status[`ST_DATA]);
  c_overflow: cover property (message_end_event_out && rx_frame_status[`ST_OVF]);
  c_acknowledge: cover property (held && done_write);

endmodule

// ### test/remote_station.sv
`timescale 1ns/1ns
module remote_station (
  // Transmit side.
  input  wire logic       clock_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_byte_in,
  output logic            tx_ready_out,
  // Receive side.
  output logic            rx_valid_out,
  output logic      [7:0] rx_byte_out,
  output logic            rx_end_out,
  output logic            rx_crc_ok_out,
  output logic            rx_abort_out
);
  logic [7:0] got [$];
  initial {tx_ready_out, rx_valid_out, rx_byte_out, rx_end_out, rx_crc_ok_out, rx_abort_out} = 13'h0;
  // Ready every other edge, so the sender must really hold each byte.
  always @(posedge clock_in) begin
    if (tx_valid_in && tx_ready_out) got.push_back(tx_byte_in);
    tx_ready_out <= tx_valid_in && !tx_ready_out;
  end
  // Three header bytes, then counted data, then an end or an abort.
  task send(input logic [23:0] h, input int nd, input logic ok, input logic ab);
    for (int i = 0; i < nd + 3; i++) begin
      rx_valid_out <= 1'h1;
      rx_byte_out <= (i < 3) ? h[23 - 8 * i -: 8] : 8'(i);
      @(posedge clock_in);
    end
    {rx_valid_out, rx_end_out, rx_abort_out, rx_crc_ok_out} <= {1'h0, ~ab, ab, ok};
    rx_byte_out <= ~rx_byte_out;
    @(posedge clock_in);
    {rx_end_out, rx_abort_out} <= 2'h0;
    @(posedge clock_in);
  endtask
endmodule

// ### test/test_hdlc_address_recognition_status.sv
`timescale 1ns/1ns
`include "hdlc_addr_defines.svh"
module test_hdlc_address_recognition_status;
  logic        clock_in, rst_in, psel, pen, pwr, rdy, err, se, rv, re, rc, ra, frdy;
  logic        push, ev, cmd, treq, tresp, trdy, tv, modulo_select;
  logic [9:0]  pa;
  logic [31:0] pwd, prd;
  logic [7:0]  rb, fd, tb, q;
  logic [27:0] rows [7] = '{28'h1003a90, 28'h12ffaa1, 28'h2005a10, 28'h20ffa00, 28'hfc03a50, 28'hfe05a71,
                            28'hfcffa40};
  int          n_fail = 0;
  int          tests_run = 0;
  hdlc_address_recognition_status i_dut (.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy), .pslverr_out(err),
    .rx_valid_in(rv), .rx_byte_in(rb), .rx_end_in(re), .rx_crc_ok_in(rc), .rx_abort_in(ra),
    .rx_fifo_ready_in(frdy), .rx_fifo_push_out(push), .rx_fifo_data_out(fd), .message_end_event_out(ev),
    .rx_is_command_out(cmd), .tx_req_in(treq), .tx_response_in(tresp), .tx_ready_in(trdy), .tx_valid_out(tv),
    .tx_byte_out(tb), .modulo_select_out(modulo_select));
  remote_station i_far (.clock_in(clock_in), .tx_valid_in(tv), .tx_byte_in(tb), .tx_ready_out(trdy),
    .rx_valid_out(rv), .rx_byte_out(rb), .rx_end_out(re), .rx_crc_ok_out(rc), .rx_abort_out(ra));
  task chk(input logic [7:0] g, input logic [7:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // Waits for pready as long as it takes; only the watchdog ends a hung transfer.
  task apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    {psel, pen, pwr, pa, pwd} <= {2'h2, w, i, 2'h0, 24'h0, d};
    @(posedge clock_in);
    pen <= 1'h1;
    do @(posedge clock_in); while (rdy !== 1'h1);
    q = prd[7:0];
    se = err;
    {psel, pen} <= 2'h0;
    // The idle cycle keeps a following call from driving psel twice in one time step.
    @(posedge clock_in);
  endtask
  task txr(input logic r);
    i_far.got.delete();
    {treq, tresp} <= {1'h1, r};
    @(posedge clock_in);
    treq <= 1'h0;
    do @(posedge clock_in); while (tv !== 1'h0);
  endtask
  task report_and_stop;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    clock_in = 1'h0;
    forever #20 clock_in = ~clock_in;
  end
  // The run needs a few hundred cycles; this leaves wide margin.
  initial begin
    #1000000;
    n_fail++;
    report_and_stop;
  end
  initial begin
    {rst_in, psel, pen, pwr, treq, tresp, frdy, pa, pwd} = {7'h41, 42'h0};
    repeat (4) @(posedge clock_in);
    rst_in <= 1'h0;
    @(posedge clock_in);
    apb(0, `IDX_RX_COUNT, 8'h0);
    chk(q, `COUNT_RESET, "count reset");
    apb(1, `IDX_RX_COUNT, 8'h5a);
    apb(0, `IDX_RX_COUNT, 8'h0);
    chk(q, 8'h00, "shared index");
    apb(0, 8'h30, 8'h0);
    chk({7'h0, se}, 8'h01, "unmapped");
    apb(1, `IDX_MODE, 8'h08);
    apb(1, `IDX_RX_ADDR, 8'h10);
    apb(1, `IDX_RX_STATUS, 8'h22);
    apb(1, `IDX_TEI_FIRST, 8'h03);
    apb(1, `IDX_TEI_SECOND, 8'h05);
    chk({7'h0, modulo_select}, 8'h01, "modulo");
    // Modulo 128 in auto-mode eats two control bytes, so one data byte needs two after the header.
    for (int i = 0; i < 7; i++) begin
      i_far.send({rows[i][27:12], 8'h03}, 2, 1'h1, 1'h0);
      apb(0, `IDX_RX_STATUS, 8'h0);
      chk(q, rows[i][11:4], "status");
      chk({7'h0, cmd}, {7'h0, rows[i][0]}, "command");
      apb(0, `IDX_RX_COUNT, 8'h0);
      chk(q, 8'h01, "count");
      apb(1, `IDX_CMD, 8'h01);
    end
    $display("table done");
    apb(1, `IDX_RX_STATUS, 8'h12);
    i_far.send(24'h100503, 2, 1'h1, 1'h0);
    apb(0, `IDX_RX_STATUS, 8'h0);
    chk(q, 8'ha9, "equal SAPIs");
    apb(1, `IDX_CMD, 8'h01);
    i_far.send(24'h100303, 33, 1'h1, 1'h0);
    apb(0, `IDX_RX_COUNT, 8'h0);
    chk(q, 8'h20, "32 bytes");
    apb(1, `IDX_CMD, 8'h01);
    frdy <= 1'h0;
    i_far.send(24'h100303, 2, 1'h0, 1'h0);
    frdy <= 1'h1;
    i_far.send(24'h100503, 2, 1'h1, 1'h0);
    apb(0, `IDX_RX_STATUS, 8'h0);
    chk(q, 8'h49, "overflow held");
    apb(1, `IDX_CMD, 8'h01);
    i_far.send(24'h100303, 2, 1'h1, 1'h1);
    apb(0, `IDX_RX_STATUS, 8'h0);
    chk(q, 8'h99, "abort");
    apb(1, `IDX_CMD, 8'h01);
    apb(1, `IDX_MODE, 8'h0a);
    i_far.send(24'h540303, 1, 1'h1, 1'h0);
    apb(0, `IDX_RX_ADDR, 8'h0);
    chk(q, 8'h54, "first byte");
    apb(1, `IDX_CMD, 8'h01);
    apb(1, `IDX_MODE, 8'h0c);
    i_far.send(24'h100303, 1, 1'h1, 1'h0);
    apb(0, `IDX_RX_STATUS, 8'h0);
    chk(q, 8'ha8, "transparent 3 status");
    apb(0, `IDX_RX_COUNT, 8'h0);
    chk(q, 8'h03, "transparent 3 count");
    apb(1, `IDX_CMD, 8'h01);
    $display("status done");
    apb(1, `IDX_MODE, 8'h08);
    apb(1, `IDX_TX_FIRST, 8'h10);
    apb(1, `IDX_RX_COUNT, 8'h03);
    for (int i = 0; i < 4; i++) begin
      apb(1, `IDX_RX_ADDR, {6'h04, i[1], 1'h0});
      txr(i[0]);
      chk(i_far.got[0], {6'h04, i[1] ^ i[0], 1'h0}, "tx first");
      chk(i_far.got[1], 8'h03, "tx second");
    end
    apb(1, `IDX_RX_ADDR, 8'h10);
    apb(1, `IDX_MODE, 8'h00);
    txr(1'h0);
    chk(i_far.got[0], 8'h10, "tx command");
    txr(1'h1);
    chk(i_far.got[0], 8'h03, "tx response");
    chk(8'(i_far.got.size()), 8'h01, "tx length");
    $display("transmit done");
    report_and_stop;
  end
endmodule
